// ### logic/asp_pkg.sv
// Constants shared by the audio serial port block
// Assumes 8-bit registers at the byte offsets below
package asp_pkg;
  // ==========================================
  // Sizes
  localparam int WORD_W = 32;
  localparam int FIFO_DEPTH = 4;
  // ==========================================
  // Register offsets and reset values
  localparam logic [7:0] ADDR_CTRL0 = 8'h18;
  localparam logic [7:0] ADDR_CTRL1 = 8'h19;
  localparam logic [7:0] ADDR_FRAME = 8'h1a;
  localparam logic [7:0] ADDR_TX0 = 8'h1b;
  localparam logic [7:0] RST_CTRL0 = 8'h40;
  localparam logic [7:0] RST_CTRL1 = 8'h00;
  localparam logic [7:0] RST_FRAME = 8'h30;
  localparam logic [7:0] RST_TX0 = 8'h00;
  localparam logic [7:0] WMASK_CTRL1 = 8'hfe;
  localparam logic [31:0] CFG_RST = {RST_CTRL0, RST_CTRL1, RST_FRAME,
    RST_TX0};
  // ==========================================
  // Field positions
  localparam int MAIN_OFF_BIT = 7;
  localparam int SECOND_OFF_BIT = 6;
  localparam int FOLLOW_BIT = 5;
  localparam int CHAIN_MSB = 4;
  localparam int CHAIN_LSB = 3;
  localparam int DSRC_MSB = 2;
  localparam int OSPLIT_MSB = 7;
  localparam int OSPLIT_LSB = 6;
  localparam int ISPLIT_MSB = 5;
  localparam int ISPLIT_LSB = 4;
  localparam int DDIR_BIT = 3;
  localparam int FMT_MSB = 7;
  localparam int FMT_LSB = 6;
  localparam int LEN_MSB = 5;
  localparam int LEN_LSB = 4;
  localparam int FSINV_BIT = 3;
  localparam int BCINV_BIT = 2;
  localparam int ERROFF_BIT = 1;
  localparam int RESOFF_BIT = 0;
  localparam int EDGE_BIT = 7;
  localparam int FILL_BIT = 6;
  localparam int LSBH_BIT = 5;
  // ==========================================
  // Field encodings
  localparam logic [1:0] FMT_TDM = 2'h0;
  localparam logic [1:0] FMT_I2S = 2'h1;
  localparam logic [1:0] FMT_LJ = 2'h2;
  localparam logic [1:0] FMT_RSV = 2'h3;
  localparam logic [1:0] CHAIN_OFF = 2'h0;
  localparam logic [1:0] CHAIN_MAIN = 2'h1;
  localparam logic [1:0] CHAIN_SECOND = 2'h2;
  localparam logic [2:0] DSRC_OFF = 3'h0;
  localparam logic [2:0] DSRC_GP1 = 3'h1;
  localparam logic [2:0] DSRC_GP2 = 3'h2;
  localparam logic [2:0] DSRC_GPI = 3'h3;
  localparam logic [2:0] DSRC_DIN = 3'h5;
  localparam logic [1:0] SPLIT_EACH = 2'h0;
  localparam logic [1:0] SPLIT_MAIN = 2'h1;
  localparam logic [1:0] SPLIT_SECOND = 2'h2;
  localparam logic [1:0] ONE_LINE = 2'h1;
  localparam logic [1:0] TWO_LINES = 2'h2;
  // ==========================================
  // Bit index markers and slot lengths
  localparam logic [5:0] IDX_SKIP = 6'h3f;
  localparam logic [5:0] IDX_MAX = 6'h3e;
  localparam logic [5:0] SLOT_BITS [4] = '{6'h10, 6'h14, 6'h18, 6'h20};
  typedef enum logic [1:0] {LK_IDLE, LK_RUN, LK_HALT} asp_lnk_st_t;
endpackage

// ### logic/asp_fifo.sv
// Small synchronous FIFO for outgoing sample words
// Assumes one clock and an asynchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
module asp_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
    logic full;
  } asp_fifo_t;

  asp_fifo_t s_r;
  asp_fifo_t s_nxt;
  logic push;
  logic pop;

  // ==========================================
  // Handshake; full comes from a flop
  assign in_ready = ~s_r.full;
  assign out_valid = (s_r.cnt != '0);
  assign out_data = s_r.mem[s_r.rp];
  assign push = in_valid & ~s_r.full;
  assign pop = out_valid & out_ready;

  // Pointer and count update
  always_comb
  begin
    s_nxt = s_r;
    if (push)
    begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = (s_r.wp == PTR_LAST) ? '0 : s_r.wp + 1'b1;
    end
    if (pop)
      s_nxt.rp = (s_r.rp == PTR_LAST) ? '0 : s_r.rp + 1'b1;
    if (push & ~pop)
      s_nxt.cnt = s_r.cnt + 1'b1;
    else if (pop & ~push)
      s_nxt.cnt = s_r.cnt - 1'b1;
    s_nxt.full = (s_nxt.cnt == CNT_FULL);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
endmodule // asp_fifo
`default_nettype wire

// ### logic/asp_port.sv
// Audio serial port: configuration registers and main port transmit
// Assumes a byte register port on ref_clk and a host-driven bit clock
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Main port off bit stops main port
// - Second port off after reset
// - Follow bit makes second port copy main
// - Chain field picks chained port, removes other
// - Daisy source picks pin, reserved means off
// - Output split shares data lines between ports
// - Input split shares data inputs between ports
// - Daisy direction picks output or input path
// - Framing field picks TDM, I2S or left-justified
// - Slot length 16, 20, 24 or 32 bits
// - Frame sync invert flips frame polarity
// - Bit clock invert swaps launch edge
// - Error detect off bit disables error check
// - Auto resume off holds port down
// - Edge shift moves launch half cycle, to the other bit clock edge
// - Idle cycles drive zero or float
// - Last bit hold floats second half
module asp_port #(
  parameter int FIFO_DEPTH = asp_pkg::FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic smp_valid,
  input wire logic [asp_pkg::WORD_W-1:0] smp_data,
  output logic smp_ready,
  input wire logic bclk,
  input wire logic fsync,
  input wire logic din,
  input wire logic general_pin_one,
  input wire logic general_pin_two,
  input wire logic input_only_pin,
  output logic dout0,
  output logic dout0_oe,
  output logic dout1,
  output logic dout1_oe,
  output logic port_fault,
  output logic second_port_on,
  output logic second_port_follow,
  output logic [1:0] main_inputs,
  output logic [1:0] second_inputs,
  output logic [2:0] main_rx_src
);
  localparam int WW = asp_pkg::WORD_W;

  // ==========================================
  // State types
  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [7:0] frame;
    logic [7:0] tx0;
    logic [7:0] rdata;
    logic dirty;
    logic [31:0] cfg_sh;
    logic cfg_tgl;
    logic [WW-1:0] hold;
    logic wreq_tgl;
    logic cack_a;
    logic cack_b;
    logic wack_a;
    logic wack_b;
    logic err_a;
    logic err_b;
    logic fault;
    logic second_on;
    logic follow;
    logic [1:0] main_in;
    logic [1:0] second_in;
    logic [2:0] rx_src;
  } asp_ref_t;

  typedef struct packed {
    logic d0;
    logic oe0;
    logic d1;
    logic oe1;
    logic lsb;
    logic tag;
  } asp_bit_t;

  typedef struct packed {
    asp_pkg::asp_lnk_st_t st;
    logic [31:0] cfg;
    logic cack;
    logic creq_a;
    logic creq_b;
    logic wreq_a;
    logic wreq_b;
    logic wack;
    logic fs;
    logic fs_d;
    logic [3:0] di;
    logic [5:0] idx;
    logic slot;
    logic [WW-1:0] sh;
    logic err;
    asp_bit_t b;
  } asp_lnk_t;

  asp_ref_t r_r;
  asp_ref_t r_nxt;
  asp_lnk_t l_r;
  asp_lnk_t l_nxt;
  asp_bit_t n_r;
  asp_bit_t lb;
  logic f_valid;
  logic f_ready;
  logic [WW-1:0] f_data;

  // ==========================================
  // Word buffer between the user and the link
  asp_fifo #(
    .W(WW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(ref_clk),
    .rst(rst),
    .in_valid(smp_valid),
    .in_ready(smp_ready),
    .in_data(smp_data),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  // Pop once the link took the last word
  assign f_ready = (r_r.wreq_tgl == r_r.wack_b);

  // ==========================================
  // Register side on ref_clk
  logic [1:0] chain;
  logic [2:0] dsrc;
  logic dsrc_ok;
  assign chain = r_r.ctrl0[asp_pkg::CHAIN_MSB:asp_pkg::CHAIN_LSB];
  assign dsrc = r_r.ctrl0[asp_pkg::DSRC_MSB:0];
  assign dsrc_ok = (dsrc == asp_pkg::DSRC_GP1) |
    (dsrc == asp_pkg::DSRC_GP2) | (dsrc == asp_pkg::DSRC_GPI) |
    (dsrc == asp_pkg::DSRC_DIN);

  always_comb
  begin
    r_nxt = r_r;
    r_nxt.cack_a = l_r.cack;
    r_nxt.cack_b = r_r.cack_a;
    r_nxt.wack_a = l_r.wack;
    r_nxt.wack_b = r_r.wack_a;
    r_nxt.err_a = l_r.err;
    r_nxt.err_b = r_r.err_a;
    r_nxt.fault = r_r.err_b;
    // Snapshot held steady until the link side acknowledges it
    if (r_r.dirty && (r_r.cfg_tgl == r_r.cack_b))
    begin
      r_nxt.cfg_sh = {r_r.ctrl0, r_r.ctrl1, r_r.frame, r_r.tx0};
      r_nxt.cfg_tgl = ~r_r.cfg_tgl;
      r_nxt.dirty = 1'b0;
    end
    // Writes; a write in the snapshot cycle marks dirty again
    if (reg_wr)
    begin
      case (reg_addr)
        asp_pkg::ADDR_CTRL0:
        begin
          r_nxt.ctrl0 = reg_wdata;
          r_nxt.dirty = 1'b1;
        end
        asp_pkg::ADDR_CTRL1:
        begin
          r_nxt.ctrl1 = reg_wdata & asp_pkg::WMASK_CTRL1;
          r_nxt.dirty = 1'b1;
        end
        asp_pkg::ADDR_FRAME:
        begin
          r_nxt.frame = reg_wdata;
          r_nxt.dirty = 1'b1;
        end
        asp_pkg::ADDR_TX0:
        begin
          r_nxt.tx0 = reg_wdata;
          r_nxt.dirty = 1'b1;
        end
        default: ;
      endcase
    end
    // Read data one cycle after the address; unmapped reads zero
    case (reg_addr)
      asp_pkg::ADDR_CTRL0: r_nxt.rdata = r_r.ctrl0;
      asp_pkg::ADDR_CTRL1: r_nxt.rdata = r_r.ctrl1;
      asp_pkg::ADDR_FRAME: r_nxt.rdata = r_r.frame;
      asp_pkg::ADDR_TX0: r_nxt.rdata = r_r.tx0;
      default: r_nxt.rdata = 8'h00;
    endcase
    // Hand the next word to the link
    if (f_valid && f_ready)
    begin
      r_nxt.hold = f_data;
      r_nxt.wreq_tgl = ~r_r.wreq_tgl;
    end
    // Port routing decode
    r_nxt.second_on = ~r_r.ctrl0[asp_pkg::SECOND_OFF_BIT] &
      (chain != asp_pkg::CHAIN_MAIN);
    r_nxt.follow = r_r.ctrl0[asp_pkg::FOLLOW_BIT];
    case (r_r.ctrl1[asp_pkg::ISPLIT_MSB:asp_pkg::ISPLIT_LSB])
      asp_pkg::SPLIT_EACH:
      begin
        r_nxt.main_in = asp_pkg::ONE_LINE;
        r_nxt.second_in = asp_pkg::ONE_LINE;
      end
      asp_pkg::SPLIT_MAIN:
      begin
        r_nxt.main_in = asp_pkg::TWO_LINES;
        r_nxt.second_in = 2'h0;
      end
      asp_pkg::SPLIT_SECOND:
      begin
        r_nxt.main_in = 2'h0;
        r_nxt.second_in = asp_pkg::TWO_LINES;
      end
      default:
      begin
        r_nxt.main_in = 2'h0;
        r_nxt.second_in = 2'h0;
      end
    endcase
    // Input-side chaining feeds the main port from the daisy pin
    if ((chain == asp_pkg::CHAIN_MAIN) &&
        r_r.ctrl1[asp_pkg::DDIR_BIT])
      r_nxt.rx_src = dsrc_ok ? dsrc : asp_pkg::DSRC_OFF;
    else
      r_nxt.rx_src = asp_pkg::DSRC_DIN;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      r_r <= '0;
      r_r.ctrl0 <= asp_pkg::RST_CTRL0;
      r_r.ctrl1 <= asp_pkg::RST_CTRL1;
      r_r.frame <= asp_pkg::RST_FRAME;
      r_r.tx0 <= asp_pkg::RST_TX0;
      r_r.cfg_sh <= asp_pkg::CFG_RST;
      r_r.main_in <= asp_pkg::ONE_LINE;
      r_r.second_in <= asp_pkg::ONE_LINE;
      r_r.rx_src <= asp_pkg::DSRC_DIN;
    end
    else
      r_r <= r_nxt;
  end

  // ==========================================
  // Link side on bclk, using the applied settings
  logic [7:0] c0;
  logic [7:0] c1;
  logic [7:0] fr;
  logic [7:0] tx;
  logic [1:0] fmt;
  logic [5:0] len;
  logic [5:0] lastix;
  logic fsp;
  logic rise;
  logic any;
  logic pend;
  logic run_ok;
  logic err_now;
  logic dbit;
  assign c0 = l_r.cfg[31:24];
  assign c1 = l_r.cfg[23:16];
  assign fr = l_r.cfg[15:8];
  assign tx = l_r.cfg[7:0];
  assign fmt = fr[asp_pkg::FMT_MSB:asp_pkg::FMT_LSB];
  assign len = asp_pkg::SLOT_BITS[fr[asp_pkg::LEN_MSB:asp_pkg::LEN_LSB]];
  assign lastix = len - 6'h01;
  // I2S frames begin on the falling sync, so fold that into polarity
  assign fsp = l_r.fs ^ fr[asp_pkg::FSINV_BIT] ^
    (fmt == asp_pkg::FMT_I2S);
  assign rise = fsp & ~l_r.fs_d;
  assign any = fsp ^ l_r.fs_d;
  assign pend = (l_r.creq_b != l_r.cack);
  assign run_ok = ~c0[asp_pkg::MAIN_OFF_BIT] &
    (c0[asp_pkg::CHAIN_MSB:asp_pkg::CHAIN_LSB] != asp_pkg::CHAIN_SECOND)
    & (fmt != asp_pkg::FMT_RSV);
  // Sync arriving before the slots are complete is a bus error
  assign err_now = (fmt == asp_pkg::FMT_TDM) ?
    (rise & ~(l_r.slot & (l_r.idx >= lastix))) :
    (any & (l_r.idx < lastix));

  // Daisy source pick; reserved codes give zero
  always_comb
  begin
    case (c0[asp_pkg::DSRC_MSB:0])
      asp_pkg::DSRC_DIN: dbit = l_r.di[0];
      asp_pkg::DSRC_GP1: dbit = l_r.di[1];
      asp_pkg::DSRC_GP2: dbit = l_r.di[2];
      asp_pkg::DSRC_GPI: dbit = l_r.di[3];
      default: dbit = 1'b0;
    endcase
  end

  always_comb
  begin
    logic go;
    logic edge_ev;
    logic emit;
    logic [5:0] cidx;
    logic cslot;
    logic used;
    logic two_main;
    logic fwd;
    logic bitv;
    logic [WW-1:0] w;
    go = 1'b0;
    edge_ev = 1'b0;
    emit = 1'b0;
    cidx = l_r.idx;
    cslot = l_r.slot;
    used = 1'b0;
    w = '0;
    l_nxt = l_r;
    l_nxt.creq_a = r_r.cfg_tgl;
    l_nxt.creq_b = l_r.creq_a;
    l_nxt.wreq_a = r_r.wreq_tgl;
    l_nxt.wreq_b = l_r.wreq_a;
    l_nxt.fs = fsync;
    l_nxt.fs_d = fsp;
    l_nxt.di = {input_only_pin, general_pin_two, general_pin_one, din};
    l_nxt.b = '0;
    l_nxt.b.tag = ~l_r.b.tag;
    case (l_r.st)
      asp_pkg::LK_IDLE:
      begin
        if (pend)
        begin
          l_nxt.cfg = r_r.cfg_sh;
          l_nxt.cack = l_r.creq_b;
        end
        else
          go = rise & run_ok;
      end
      asp_pkg::LK_RUN:
      begin
        if (~run_ok)
          l_nxt.st = asp_pkg::LK_IDLE;
        else if (rise & pend)
        begin
          // New settings only between frames
          l_nxt.cfg = r_r.cfg_sh;
          l_nxt.cack = l_r.creq_b;
          l_nxt.st = asp_pkg::LK_IDLE;
        end
        else if (err_now & ~fr[asp_pkg::ERROFF_BIT])
        begin
          l_nxt.st = asp_pkg::LK_HALT;
          l_nxt.err = 1'b1;
        end
        else
        begin
          emit = 1'b1;
          edge_ev = (fmt == asp_pkg::FMT_TDM) ? rise : any;
        end
      end
      asp_pkg::LK_HALT:
      begin
        if (pend)
        begin
          // Host reconfiguration releases a held port
          l_nxt.cfg = r_r.cfg_sh;
          l_nxt.cack = l_r.creq_b;
          l_nxt.err = 1'b0;
          l_nxt.st = asp_pkg::LK_IDLE;
        end
        else
          go = rise & run_ok & ~fr[asp_pkg::RESOFF_BIT];
      end
      default: l_nxt.st = asp_pkg::LK_IDLE;
    endcase
    if (go)
    begin
      l_nxt.st = asp_pkg::LK_RUN;
      l_nxt.err = 1'b0;
      emit = 1'b1;
      edge_ev = 1'b1;
    end
    // Slot position for this bit period
    if (edge_ev)
    begin
      cidx = (fmt == asp_pkg::FMT_I2S) ? asp_pkg::IDX_SKIP : 6'h00;
      cslot = (fmt == asp_pkg::FMT_TDM) ? 1'b0 : ~rise;
    end
    used = emit & (cidx < len);
    // Word taken at slot start; an empty buffer sends zeros
    if (used && (cidx == 6'h00) && (l_r.wreq_b != l_r.wack))
    begin
      w = r_r.hold;
      l_nxt.wack = l_r.wreq_b;
    end
    bitv = (cidx == 6'h00) ? w[WW-1] : l_r.sh[WW-1];
    if (used)
      l_nxt.sh = (cidx == 6'h00) ? {w[WW-2:0], 1'b0} :
        {l_r.sh[WW-2:0], 1'b0};
    // Next slot position; TDM runs slot 1 straight after slot 0
    if (emit)
    begin
      if ((fmt == asp_pkg::FMT_TDM) && ~cslot && (cidx == lastix))
      begin
        l_nxt.slot = 1'b1;
        l_nxt.idx = 6'h00;
      end
      else
      begin
        l_nxt.slot = cslot;
        if (cidx == asp_pkg::IDX_SKIP)
          l_nxt.idx = 6'h00;
        else if (cidx == asp_pkg::IDX_MAX)
          l_nxt.idx = asp_pkg::IDX_MAX;
        else
          l_nxt.idx = cidx + 6'h01;
      end
    end
    // Line assignment and idle-cycle fill
    two_main = (c1[asp_pkg::OSPLIT_MSB:asp_pkg::OSPLIT_LSB] ==
      asp_pkg::SPLIT_MAIN);
    fwd = (c0[asp_pkg::CHAIN_MSB:asp_pkg::CHAIN_LSB] ==
      asp_pkg::CHAIN_MAIN) & ~c1[asp_pkg::DDIR_BIT];
    if (emit)
    begin
      if (used & (~two_main | ~cslot))
      begin
        l_nxt.b.d0 = bitv;
        l_nxt.b.oe0 = 1'b1;
      end
      else
      begin
        l_nxt.b.d0 = fwd & dbit;
        l_nxt.b.oe0 = fwd | ~tx[asp_pkg::FILL_BIT];
      end
      if (two_main)
      begin
        l_nxt.b.d1 = used & cslot & bitv;
        l_nxt.b.oe1 = (used & cslot) | ~tx[asp_pkg::FILL_BIT];
      end
      l_nxt.b.lsb = used & (cidx == lastix);
    end
  end

  always_ff @(posedge bclk or posedge rst)
  begin
    if (rst)
    begin
      l_r <= '0;
      l_r.cfg <= asp_pkg::CFG_RST;
    end
    else
      l_r <= l_nxt;
  end

  // Opposite-edge copy gives the half-cycle launch choice
  always_ff @(negedge bclk or posedge rst)
  begin
    if (rst)
      n_r <= '0;
    else
      n_r <= l_r.b;
  end

  // ==========================================
  // Pins: launch flop chosen by polarity and edge shift
  logic launch_neg;
  logic half2;
  logic lsb_z;
  assign launch_neg = ~(fr[asp_pkg::BCINV_BIT] ^
    tx[asp_pkg::EDGE_BIT]);
  assign lb = launch_neg ? n_r : l_r.b;
  // Unequal tags with falling launch, equal with rising, mean the other edge has passed inside this bit
  assign half2 = launch_neg ? (l_r.b.tag != n_r.tag) :
    (l_r.b.tag == n_r.tag);
  assign lsb_z = tx[asp_pkg::LSBH_BIT] & lb.lsb & half2;
  assign dout0 = lb.d0;
  assign dout0_oe = lb.oe0 & ~lsb_z;
  assign dout1 = lb.d1;
  assign dout1_oe = lb.oe1 & ~lsb_z;
  assign reg_rdata = r_r.rdata;
  assign port_fault = r_r.fault;
  assign second_port_on = r_r.second_on;
  assign second_port_follow = r_r.follow;
  assign main_inputs = r_r.main_in;
  assign second_inputs = r_r.second_in;
  assign main_rx_src = r_r.rx_src;
endmodule // asp_port
`default_nettype wire

// ### bench/asp_port_sva.sv
// Checker for the audio serial port block
// Bound to asp_port below; sees only its ports
`timescale 1ns/1ns
`default_nettype none
module asp_port_sva #(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic smp_ready,
  input wire logic dout0_oe,
  input wire logic dout1_oe,
  input wire logic port_fault,
  input wire logic second_port_on,
  input wire logic second_port_follow,
  input wire logic [1:0] main_inputs,
  input wire logic [1:0] second_inputs
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // ====================
  // Shadow of control bytes
  logic [7:0] c0_r;
  logic [7:0] c1_r;
  logic [1:0] age_r;
  logic [3:0] ins;
  // Flags are registered: judge them 3 cycles after a write
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      c0_r <= 8'h40;
      c1_r <= 8'h00;
      age_r <= 2'h3;
    end
    else if (reg_wr)
    begin
      age_r <= 2'h0;
      if (reg_addr == asp_pkg::ADDR_CTRL0)
        c0_r <= reg_wdata;
      if (reg_addr == asp_pkg::ADDR_CTRL1)
        c1_r <= reg_wdata;
    end
    else if (age_r != 2'h3)
      age_r <= age_r + 2'h1;
  end
  // Input counts {main, second}; reserved code gives none
  always_comb
  begin
    case (c1_r[5:4])
      2'h0: ins = 4'h5;
      2'h1: ins = 4'h8;
      2'h2: ins = 4'h2;
      default: ins = 4'h0;
    endcase
  end
  // ====================
  // Assertions
  rdata_unmap_a: assert property (
    !($past(reg_addr) inside {[8'h18:8'h1b]}) |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  ctrl1_bit0_a: assert property (
    $past(reg_addr) == asp_pkg::ADDR_CTRL1 |-> !reg_rdata[0])
    else $error("read-only bit set");
  wr_rd_a: assert property (
    reg_wr && reg_addr == asp_pkg::ADDR_FRAME ##1
    !reg_wr && reg_addr == asp_pkg::ADDR_FRAME
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("framing readback wrong");
  sec_on_a: assert property (
    age_r == 2'h3 |-> second_port_on ==
    (!c0_r[6] && c0_r[4:3] != asp_pkg::CHAIN_MAIN))
    else $error("second port enable wrong");
  follow_a: assert property (
    age_r == 2'h3 |-> second_port_follow == c0_r[5])
    else $error("follow flag wrong");
  split_in_a: assert property (
    age_r == 2'h3 |-> {main_inputs, second_inputs} == ins)
    else $error("input split wrong");
  fault_float_a: assert property (
    $rose(port_fault) |-> !dout0_oe && !dout1_oe)
    else $error("lines driven during fault");
  reset_vals_a: assert property (
    $fell(rst) |-> smp_ready && !port_fault && !second_port_on)
    else $error("outputs wrong after reset");
  cover property ($rose(port_fault));
  cover property (reg_wr && reg_addr == asp_pkg::ADDR_CTRL0);
  cover property ($fell(smp_ready));
endmodule // asp_port_sva
bind asp_port asp_port_sva #(.FIFO_DEPTH(FIFO_DEPTH)) u_sva (.ref_clk,
  .rst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .smp_ready, .dout0_oe,
  .dout1_oe, .port_fault, .second_port_on, .second_port_follow,
  .main_inputs, .second_inputs);
`default_nettype wire

// ### bench/asp_host_model.sv
// Host audio port model: makes bit clock and frame sync
// Clock idles between bursts
`timescale 1ns/1ns
`default_nettype none
module asp_host_model (
  output logic bclk,
  output logic fsync,
  input wire logic dout0,
  input wire logic dout0_oe
);
  logic [79:0] lo_d;
  logic [79:0] lo_oe;
  logic [79:0] hi_oe;
  initial
  begin
    bclk = 1'b0;
    fsync = 1'b0;
  end
  // One 12 ns bit; line read mid phase
  task automatic tick(input logic s, input int k, input logic cap);
  begin
    fsync = s;
    #3 bclk = 1'b1;
    #3 if (cap) hi_oe[k] = dout0_oe;
    #3 bclk = 1'b0;
    #3 if (cap) {lo_d[k], lo_oe[k]} = {dout0, dout0_oe};
  end
  endtask
  // TDM frames of two n-bit slots, one-bit sync pulse
  task automatic burst(input int n, input int nf, input int bad);
    int f;
    int k;
  begin
    for (k = 0; k < 16; k++)
      tick(1'b0, 0, 1'b0);
    for (f = 0; f < nf; f++)
      for (k = 0; k < 2 * n + 4; k++)
        tick(k == 0 || (f == nf - 1 && k == bad), k, f == nf - 1);
  end
  endtask
endmodule // asp_host_model
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for asp_port
// Host model drives the link
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam int DEPTH = 4;
  localparam logic [31:0] W0 = 32'ha5c3_9e17;
  localparam logic [31:0] W1 = 32'h6b2d_f048;
  logic ref_clk, rst, reg_wr, smp_valid, smp_ready, bclk, fsync;
  logic dout0, dout0_oe, dout1, dout1_oe, port_fault;
  logic second_port_on, second_port_follow;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [31:0] smp_data;
  logic [1:0] main_inputs, second_inputs;
  logic [2:0] main_rx_src;
  int fail_count;
  int n_compared;
  asp_port #(.FIFO_DEPTH(DEPTH)) uut (.ref_clk, .rst, .reg_wr, .reg_addr,
    .reg_wdata, .reg_rdata, .smp_valid, .smp_data, .smp_ready, .bclk,
    .fsync, .din(1'b0), .general_pin_one(1'b0), .general_pin_two(1'b0),
    .input_only_pin(1'b0), .dout0, .dout0_oe, .dout1, .dout1_oe,
    .port_fault, .second_port_on, .second_port_follow, .main_inputs,
    .second_inputs, .main_rx_src);
  asp_host_model host (.bclk, .fsync, .dout0, .dout0_oe);
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // ====================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task automatic final_report;
  begin
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  // Link side needs bclk edges in reset
  task automatic do_reset;
  begin
    rst <= 1'b1;
    fork
      repeat (5) @(posedge ref_clk);
      repeat (4) host.tick(1'b0, 0, 1'b0);
    join
    @(posedge ref_clk);
    rst <= 1'b0;
  end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
  begin
    @(posedge ref_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
  begin
    @(posedge ref_clk);
    reg_addr <= a;
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk(reg_rdata, e);
  end
  endtask
  task automatic push(input logic [31:0] w);
    int t;
    logic ok;
  begin
    t = 0;
    @(posedge ref_clk);
    {smp_valid, smp_data} <= {1'b1, w};
    do
    begin
      @(negedge ref_clk);
      ok = smp_ready;
      @(posedge ref_clk);
      t++;
    end
    while (ok !== 1'b1 && t < 40);
    if (t >= 40)
    begin
      fail_count++;
      final_report();
    end
    smp_valid <= 1'b0;
  end
  endtask
  // ====================
  // Scenarios
  task automatic t_regs;
  begin
    do_reset();
    rdchk(8'h18, 8'h40);
    rdchk(8'h19, 8'h00);
    rdchk(8'h1a, 8'h30);
    rdchk(8'h1b, 8'h00);
    wr(8'h1c, 8'h55);
    rdchk(8'h1c, 8'h00);
    wr(8'h19, 8'h98);
    rdchk(8'h19, 8'h98);
    chk(second_port_on, 1'b0);
    $display("t_regs done");
  end
  endtask
  task automatic t_flags;
    int c;
  begin
    for (c = 0; c < 6; c++)
    begin
      wr(8'h18, {1'b0, c[0], c[0], c[2:1], 3'h0});
      repeat (4) @(posedge ref_clk);
      chk(second_port_on, !c[0] && c[2:1] != 2'h1);
      chk(second_port_follow, c[0]);
    end
    for (c = 0; c < 3; c++)
    begin
      wr(8'h19, {2'h0, c[1:0], 4'h0});
      repeat (4) @(posedge ref_clk);
      chk({main_inputs, second_inputs}, c == 0 ? 4'h5 : c == 1 ? 4'h8 : 4'h2);
    end
    wr(8'h19, 8'h08);
    for (c = 0; c < 6; c++)
      if (c != 4)
      begin
        wr(8'h18, {5'h01, c[2:0]});
        host.burst(0, 0, 0);
        chk(main_rx_src, c[2:0]);
      end
    wr(8'h19, 8'h00);
    host.burst(0, 0, 0);
    chk(main_rx_src, 3'h5);
    $display("t_flags done");
  end
  endtask
  task automatic t_data;
    int c;
    int n;
    int i;
  begin
    for (c = 0; c < 4; c++)
    begin
      do_reset();
      n = (c == 3) ? 32 : 16 + 4 * c;
      wr(8'h1a, {2'h0, c[1:0], 4'h0});
      push(W0);
      push(W1);
      host.burst(n, 1, 0);
      for (i = 0; i < 2 * n; i++)
        chk(host.lo_d[i + 1], i < n ? W0[31 - i] : W1[31 - i + n]);
      chk({host.lo_oe[2 * n + 1], host.lo_d[2 * n + 1]}, 2'h2);
      chk(host.hi_oe[n + 1], 1'b1);
    end
    // Float idle cycles and second half of each last bit
    wr(8'h1b, 8'h60);
    push(W0);
    push(W1);
    host.burst(32, 2, 0);
    chk({host.lo_oe[1], host.lo_oe[65], host.hi_oe[33]}, 3'h4);
    wr(8'h18, 8'hc0);
    host.burst(32, 2, 0);
    chk(host.lo_oe[1], 1'b0);
    $display("t_data done");
  end
  endtask
  task automatic t_err;
    int m;
  begin
    for (m = 0; m < 3; m++)
    begin
      do_reset();
      wr(8'h1a, m[7:0]);
      host.burst(16, 3, 9);
      repeat (8) @(posedge ref_clk);
      chk(port_fault, m != 2);
      if (m != 2)
        chk(dout0_oe, 1'b0);
      host.burst(16, 1, 0);
      repeat (8) @(posedge ref_clk);
      chk(port_fault, m == 1);
      if (m == 1)
      begin
        wr(8'h1b, 8'h00);
        host.burst(16, 1, 0);
        repeat (8) @(posedge ref_clk);
        chk(port_fault, 1'b0);
      end
    end
    $display("t_err done");
  end
  endtask
  // Fill with link stopped, then drain
  task automatic t_fifo;
    int acc;
    int t;
  begin
    do_reset();
    acc = 0;
    @(posedge ref_clk);
    {smp_valid, smp_data} <= {1'b1, W0};
    for (t = 0; t < 10; t++)
    begin
      @(negedge ref_clk);
      if (smp_ready === 1'b1)
        acc++;
      @(posedge ref_clk);
    end
    smp_valid <= 1'b0;
    chk(acc >= DEPTH && acc <= DEPTH + 1, 1'b1);
    chk(smp_ready, 1'b0);
    host.burst(16, 4, 0);
    chk(smp_ready, 1'b1);
    $display("t_fifo done");
  end
  endtask
  initial
  begin
    {rst, reg_wr, smp_valid} = 3'h4;
    {reg_addr, reg_wdata, smp_data} = 48'h0;
    fail_count = 0;
    n_compared = 0;
    t_regs();
    t_flags();
    t_data();
    t_err();
    t_fifo();
    final_report();
  end
  initial
  begin
    #3000000;
    fail_count++;
    $display("[ERR] %0t run timed out", $time);
    final_report();
  end
endmodule // testbench
`default_nettype wire
